// *** hdl/ebig_pkg.sv ***
// constants shared by both ends of the external bus to isa glue
// assumes one system clock; no software-visible registers in the glue
package ebig_pkg;

  // ****************************************
  // bus widths
  // ****************************************
  localparam int BUS_DATA_W = 16;
  localparam int BUS_ADDR_W = 24;
  localparam int CPU_ADDR_W = 32;
  localparam int NUM_BANKS  = 4;
  localparam int WAIT_W     = 4;

  // ****************************************
  // processor address map
  // ****************************************
  localparam int         REGION_LSB      = 27;
  localparam logic [4:0] EXT_REGION      = 5'h0c;
  localparam int         BANK_LSB        = 25;
  localparam int         BANK_W          = 2;
  localparam logic [1:0] NIC_BANK        = 2'h2;
  localparam int         UPPER_ADDR_BIT  = 23;
  localparam int         SPACE_SEL_ADDR_BIT = 12;

  // ****************************************
  // wait states for the controller bank
  // ****************************************
  localparam logic [WAIT_W-1:0] NIC_MIN_WAIT = 4'h7;
  localparam logic [WAIT_W-1:0] NIC_REC_WAIT = 4'h8;

  // ****************************************
  // controller address decode
  // ****************************************
  localparam logic [BUS_ADDR_W-1:0] IO_BASE = 24'h000300;
  localparam int                    IO_WIN_BITS = 4;
  localparam logic [15:0]           MEM_BASE_SETTING = 16'h1000;
  localparam logic [15:0]           MEM_BASE_RESET   = 16'h0000;
  localparam int                    MEM_WIN_BITS = 5;
  localparam logic [2:0]            PORT_RX_DATA  = 3'h0;
  localparam logic [2:0]            PORT_STATUS   = 3'h1;
  localparam logic [2:0]            PORT_MEM_BASE = 3'h2;

endpackage

// *** hdl/ebig_isa_if.sv ***
// isa-side wires between the glue (host modport) and the controller
// the data bus is split; each end reads the other's lane directly and nothing resolves sd
`timescale 1ns/10ps
`default_nettype none
interface ebig_isa_if;
  import ebig_pkg::*;
  logic [BUS_ADDR_W-1:0] sa;
  logic [BUS_DATA_W-1:0] sd_host;
  logic                  sd_host_oe;
  logic [BUS_DATA_W-1:0] sd_ctrl;
  logic                  sd_ctrl_oe;
  logic                  ior_n;
  logic                  iow_n;
  logic                  memr_n;
  logic                  memw_n;
  logic                  sbhe_n;
  logic                  nic_reset_n;
  logic                  intrq;

  modport host (
    output sa, sd_host, sd_host_oe, ior_n, iow_n, memr_n, memw_n, sbhe_n, nic_reset_n,
    input  sd_ctrl, sd_ctrl_oe, intrq
  );
  modport ctrl (
    input  sa, sd_host, sd_host_oe, ior_n, iow_n, memr_n, memw_n, sbhe_n, nic_reset_n,
    output sd_ctrl, sd_ctrl_oe, intrq
  );
endinterface
`default_nettype wire

// *** hdl/ebig_host_end.sv ***
// processor end: external bus with four banks plus isa glue for bank two
// assumes requests arrive synchronous to i_sys_clk, one at a time
//
// Notes on behaviour
// - 16-bit data, 24-bit address, non-multiplexed bus
// - four banks of 32 megabytes each
// - wait states set per bank
// - controller enabled by bank two and upper bit
// - space bit low selects io space
// - space bit high selects memory space
// - io base 0x300 left at default
// - controller bank needs at least seven waits
// - eight waits recommended for margin
// - received bytes little-endian within each word
// - gpio level drives controller reset
// - controller interrupt reaches processor interrupt input
// - byte-high enable tied to address bit zero
`timescale 1ns/10ps
`default_nettype none
module ebig_host_end
  import ebig_pkg::*;
#(
  parameter logic [WAIT_W-1:0] NIC_WAIT_DEFAULT = NIC_REC_WAIT
) (
  // clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_reset_n,
  // processor request
  input  wire logic                        i_req_valid,
  input  wire logic [CPU_ADDR_W-1:0]       i_req_addr,
  input  wire logic                        i_req_write,
  input  wire logic                        i_req_byte,
  input  wire logic [BUS_DATA_W-1:0]       i_req_wdata,
  output logic                             o_req_ready,
  // processor answer
  output logic                             o_rsp_valid,
  output logic [BUS_DATA_W-1:0]            o_rsp_rdata,
  // configuration and side signals
  input  wire logic [NUM_BANKS*WAIT_W-1:0] i_bank_wait,
  input  wire logic                        i_nic_reset,
  output logic                             o_ext_irq,
  // isa side
  ebig_isa_if.host                         isa
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {EBIG_IDLE, EBIG_STROBE, EBIG_RECOVER} ebig_state_e;

  ebig_state_e             state;
  logic [WAIT_W-1:0]       wait_cnt;
  logic                    nic_sel;
  logic                    cur_write;
  logic                    cur_byte;
  logic                    cur_odd;

  // ****************************************
  // request decode
  // ****************************************
  logic                    in_region;
  logic [BANK_W-1:0]       bank;
  logic [BUS_ADDR_W-1:0]   offset;
  logic                    hit_nic;
  logic                    space_mem;
  logic [WAIT_W-1:0]       cfg_wait;
  logic [WAIT_W-1:0]       eff_wait;
  logic                    accept;

  assign in_region = (i_req_addr[CPU_ADDR_W-1:REGION_LSB] == EXT_REGION);
  assign bank      = i_req_addr[BANK_LSB +: BANK_W];
  assign offset    = i_req_addr[BUS_ADDR_W-1:0];
  assign hit_nic   = in_region && (bank == NIC_BANK)
                     && offset[UPPER_ADDR_BIT];
  assign space_mem = offset[SPACE_SEL_ADDR_BIT];
  assign cfg_wait  = i_bank_wait[bank*WAIT_W +: WAIT_W];
  // ready gates the take so a request at the first edge after reset waits
  assign accept    = (state == EBIG_IDLE) && i_req_valid && o_req_ready;

  // a zero field on the controller bank means "use the safe default"
  always_comb begin
    eff_wait = cfg_wait;
    if (bank == NIC_BANK) begin
      if (cfg_wait == '0) begin
        eff_wait = NIC_WAIT_DEFAULT;
      end else if (cfg_wait < NIC_MIN_WAIT) begin
        eff_wait = NIC_MIN_WAIT;
      end
    end
  end

  // ****************************************
  // access sequencer
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state     <= EBIG_IDLE;
      wait_cnt  <= '0;
      nic_sel   <= 1'b0;
      cur_write <= 1'b0;
      cur_byte  <= 1'b0;
      cur_odd   <= 1'b0;
    end else begin
      unique case (state)
        EBIG_IDLE: begin
          if (accept) begin
            nic_sel   <= hit_nic;
            cur_write <= i_req_write;
            cur_byte  <= i_req_byte;
            cur_odd   <= offset[0];
            wait_cnt  <= eff_wait;
            // addresses outside the four banks finish without a bus cycle
            state     <= in_region ? EBIG_STROBE : EBIG_RECOVER;
          end
        end
        EBIG_STROBE: begin
          if (wait_cnt == '0) begin
            state <= EBIG_RECOVER;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        EBIG_RECOVER: begin
          state <= EBIG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_req_ready <= 1'b0;
    end else begin
      o_req_ready <= (state == EBIG_RECOVER) || ((state == EBIG_IDLE) && !accept);
    end
  end

  // ****************************************
  // isa address, byte enable and strobes
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      isa.sa     <= '0;
      isa.sbhe_n <= 1'b0;
      isa.ior_n  <= 1'b1;
      isa.iow_n  <= 1'b1;
      isa.memr_n <= 1'b1;
      isa.memw_n <= 1'b1;
    end else if (accept) begin
      isa.sa     <= offset;
      isa.sbhe_n <= offset[0];
      // strobes only for the decoded controller window
      isa.ior_n  <= !(hit_nic && !space_mem && !i_req_write);
      isa.iow_n  <= !(hit_nic && !space_mem &&  i_req_write);
      isa.memr_n <= !(hit_nic &&  space_mem && !i_req_write);
      isa.memw_n <= !(hit_nic &&  space_mem &&  i_req_write);
    end else if ((state == EBIG_STROBE) && (wait_cnt == '0)) begin
      isa.ior_n  <= 1'b1;
      isa.iow_n  <= 1'b1;
      isa.memr_n <= 1'b1;
      isa.memw_n <= 1'b1;
    end
  end

  // ****************************************
  // write data
  // ****************************************
  // byte writes go on both lanes so an 8-bit controller sees them too
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      isa.sd_host    <= '0;
      isa.sd_host_oe <= 1'b0;
    end else if (accept) begin
      isa.sd_host    <= i_req_byte ? {i_req_wdata[7:0], i_req_wdata[7:0]} : i_req_wdata;
      isa.sd_host_oe <= hit_nic && i_req_write;
    end else if ((state == EBIG_STROBE) && (wait_cnt == '0)) begin
      isa.sd_host_oe <= 1'b0;
    end
  end

  // ****************************************
  // read data and answer
  // ****************************************
  // sampled in the last strobe cycle; the word keeps wire order,
  // first byte low, second byte high
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
    end else begin
      o_rsp_valid <= 1'b0;
      if ((state == EBIG_IDLE) && accept && !in_region) begin
        o_rsp_valid <= 1'b1;
        o_rsp_rdata <= '0;
      end else if ((state == EBIG_STROBE) && (wait_cnt == '0)) begin
        o_rsp_valid <= 1'b1;
        if (!nic_sel || cur_write) begin
          o_rsp_rdata <= '0;
        end else if (cur_byte) begin
          o_rsp_rdata <= {8'h00, cur_odd ? isa.sd_ctrl[15:8] : isa.sd_ctrl[7:0]};
        end else begin
          o_rsp_rdata <= isa.sd_ctrl;
        end
      end
    end
  end

  // ****************************************
  // reset and interrupt wiring
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      isa.nic_reset_n <= 1'b1;
      o_ext_irq       <= 1'b0;
    end else begin
      isa.nic_reset_n <= !i_nic_reset;
      o_ext_irq       <= isa.intrq;
    end
  end

endmodule
`default_nettype wire

// *** hdl/ebig_ctrl_end.sv ***
// controller end: isa slave with io window, memory window and rx word port
// assumes the isa wires are synchronous to i_sys_clk
`timescale 1ns/10ps
`default_nettype none
module ebig_ctrl_end
  import ebig_pkg::*;
#(
  parameter int MEM_WORDS = 16
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  // received wire bytes
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_byte,
  output logic            o_rx_ready,
  // status
  output logic            o_bus16,
  // isa side
  ebig_isa_if.ctrl        isa
);

  // ****************************************
  // decode
  // ****************************************
  logic                    rst_n;
  logic                    rd_n;
  logic                    wr_n;
  logic                    rd_q;
  logic                    wr_q;
  logic                    io_hit;
  logic                    mem_hit;
  logic [2:0]              port;
  logic [MEM_WIN_BITS-2:0] midx;
  logic [15:0]             mem_base;
  logic                    mem_en;
  logic [15:0]             mem [MEM_WORDS];
  logic [15:0]             rx_word;
  logic                    rx_full;
  logic                    rx_half;
  logic                    next_rx_full;
  logic                    sbhe_q;
  logic [15:0]             rd_word;
  logic [BUS_ADDR_W-1:0]   base_ext;

  // firmware gpio reset acts like the system reset
  assign rst_n    = i_reset_n && isa.nic_reset_n;
  assign rd_n     = isa.ior_n && isa.memr_n;
  assign wr_n     = isa.iow_n && isa.memw_n;
  assign base_ext = {{(BUS_ADDR_W-16){1'b0}}, mem_base};
  // the upper bit is spent on the glue's select, so decode only below it
  assign io_hit   = (isa.sa[UPPER_ADDR_BIT-1:IO_WIN_BITS] == IO_BASE[UPPER_ADDR_BIT-1:IO_WIN_BITS]);
  // window only opens once firmware has set the base
  assign mem_hit  = mem_en &&
                    (isa.sa[UPPER_ADDR_BIT-1:MEM_WIN_BITS] == base_ext[UPPER_ADDR_BIT-1:MEM_WIN_BITS]);
  assign port     = isa.sa[3:1];
  assign midx     = isa.sa[MEM_WIN_BITS-1:1];

  always_comb begin
    rd_word = '0;
    if (!isa.memr_n && mem_hit) begin
      rd_word = mem[midx];
    end else if (!isa.ior_n && io_hit) begin
      unique case (port)
        PORT_RX_DATA:  rd_word = rx_word;
        PORT_STATUS:   rd_word = {14'h0000, o_bus16, rx_full};
        PORT_MEM_BASE: rd_word = mem_base;
        default:       rd_word = '0;
      endcase
    end
  end

  // ****************************************
  // strobe edges and read drive
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      rd_q           <= 1'b0;
      wr_q           <= 1'b0;
      isa.sd_ctrl    <= '0;
      isa.sd_ctrl_oe <= 1'b0;
    end else begin
      rd_q           <= !rd_n;
      wr_q           <= !wr_n;
      isa.sd_ctrl_oe <= !rd_n && ((!isa.ior_n && io_hit) || (!isa.memr_n && mem_hit));
      // 8-bit mode repeats the addressed byte on both lanes
      if (o_bus16) begin
        isa.sd_ctrl <= rd_word;
      end else begin
        isa.sd_ctrl <= isa.sa[0] ? {rd_word[15:8], rd_word[15:8]}
                                 : {rd_word[7:0], rd_word[7:0]};
      end
    end
  end

  // ****************************************
  // bus width switch
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      o_bus16 <= 1'b0;
      // matches the host's idle level so the first access is no false edge
      sbhe_q  <= 1'b0;
    end else if ((!rd_n && !rd_q) || (!wr_n && !wr_q)) begin
      sbhe_q <= isa.sbhe_n;
      if (isa.sbhe_n != sbhe_q) begin
        o_bus16 <= 1'b1;
      end
    end
  end

  // ****************************************
  // writes: memory base and memory window
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      mem_base <= MEM_BASE_RESET;
      mem_en   <= 1'b0;
    end else if (!isa.iow_n && !wr_q && io_hit && (port == PORT_MEM_BASE)) begin
      mem_base <= isa.sd_host;
      mem_en   <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!isa.memw_n && !wr_q && mem_hit) begin
      if (o_bus16 && !isa.sbhe_n && !isa.sa[0]) begin
        mem[midx] <= isa.sd_host;
      end else if (isa.sa[0]) begin
        mem[midx][15:8] <= o_bus16 ? isa.sd_host[15:8] : isa.sd_host[7:0];
      end else begin
        mem[midx][7:0] <= isa.sd_host[7:0];
      end
    end
  end

  // ****************************************
  // receive word port and interrupt
  // ****************************************
  always_comb begin
    next_rx_full = rx_full;
    if (rd_q && rd_n && io_hit && (port == PORT_RX_DATA)) begin
      next_rx_full = 1'b0;
    end
    // a word completing now wins over the read that empties the port
    if (i_rx_valid && o_rx_ready && rx_half) begin
      next_rx_full = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      rx_word    <= '0;
      rx_half    <= 1'b0;
      rx_full    <= 1'b0;
      o_rx_ready <= 1'b0;
      isa.intrq  <= 1'b0;
    end else begin
      rx_full    <= next_rx_full;
      o_rx_ready <= !next_rx_full;
      isa.intrq  <= next_rx_full;
      if (i_rx_valid && o_rx_ready) begin
        rx_half <= !rx_half;
        if (rx_half) begin
          rx_word[15:8] <= i_rx_byte;
        end else begin
          rx_word[7:0]  <= i_rx_byte;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/ebig_isa_chk.sv ***
// checker: isa-side relations between the glue and the controller
// assumes plain copies of the interface wires, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ebig_isa_chk
  import ebig_pkg::*;
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset_n,
  input wire logic [BUS_ADDR_W-1:0] sa,
  input wire logic                  sd_host_oe,
  input wire logic                  sd_ctrl_oe,
  input wire logic                  ior_n,
  input wire logic                  iow_n,
  input wire logic                  memr_n,
  input wire logic                  memw_n,
  input wire logic                  sbhe_n,
  input wire logic                  nic_reset_n,
  input wire logic                  intrq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  wire logic idle_n = ior_n & iow_n & memr_n & memw_n;

  // ****************************************
  // sequences
  // ****************************************
  sequence s_start;
    $fell(idle_n);
  endsequence
  sequence s_held;
    !idle_n [*8];
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  a_one_strobe: assert property ((ior_n + iow_n + memr_n + memw_n) >= 3)
    else $error("two isa strobes low together");
  a_upper_bit_set: assert property (s_start |-> sa[UPPER_ADDR_BIT])
    else $error("isa strobe without upper address bit");
  a_io_space_low: assert property (!(ior_n & iow_n) |-> !sa[SPACE_SEL_ADDR_BIT])
    else $error("io strobe with space bit high");
  a_mem_space_high: assert property (!(memr_n & memw_n) |-> sa[SPACE_SEL_ADDR_BIT])
    else $error("memory strobe with space bit low");
  a_strobe_wait_len: assert property (s_start |-> s_held)
    else $error("isa strobe shorter than seven waits");
  a_addr_stable: assert property (!idle_n && $past(!idle_n) |-> $stable(sa))
    else $error("isa address moved under strobe");
  a_byte_high_tie: assert property (!idle_n |-> sbhe_n == sa[0])
    else $error("byte high enable not tied to address bit zero");
  a_no_contention: assert property (!(sd_host_oe && sd_ctrl_oe))
    else $error("both ends drive the data bus");
  a_write_drive: assert property (!(iow_n & memw_n) |-> sd_host_oe)
    else $error("write strobe without host data drive");
  a_io_read_answer: assert property ($fell(ior_n) && nic_reset_n
    && sa[11:4] == IO_BASE[11:4] |=> sd_ctrl_oe)
    else $error("controller silent on io read");
  a_reset_quiets_irq: assert property (!nic_reset_n |=> !intrq)
    else $error("interrupt high while controller held in reset");
endmodule
`default_nettype wire

// *** tb/test_ext_bus_to_isa_glue.sv ***
// testbench: processor end and controller end joined by the isa interface
// assumes a 10 mhz clock; inputs driven at the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_ext_bus_to_isa_glue
  import ebig_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_req_valid = 1'b0, i_req_write = 1'b0, i_req_byte = 1'b0;
  logic [31:0] i_req_addr = 32'h0;
  logic [15:0] i_req_wdata = 16'h0, i_bank_wait = 16'h0, o_rsp_rdata;
  logic i_nic_reset = 1'b0, i_rx_valid = 1'b0, o_req_ready, o_rsp_valid;
  logic [7:0] i_rx_byte = 8'h0;
  logic o_ext_irq, o_rx_ready, o_bus16;
  int num_errors = 0, cmp_count = 0, cycles = 0;

  always #50 i_sys_clk = ~i_sys_clk;

  ebig_isa_if isa_if ();
  ebig_host_end ebig_host_end_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_req_valid(i_req_valid), .i_req_addr(i_req_addr), .i_req_write(i_req_write),
    .i_req_byte(i_req_byte), .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .i_bank_wait(i_bank_wait),
    .i_nic_reset(i_nic_reset), .o_ext_irq(o_ext_irq), .isa(isa_if));
  ebig_ctrl_end ebig_ctrl_end_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .o_rx_ready(o_rx_ready),
    .o_bus16(o_bus16), .isa(isa_if));
  ebig_isa_chk ebig_isa_chk_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .sa(isa_if.sa), .sd_host_oe(isa_if.sd_host_oe), .sd_ctrl_oe(isa_if.sd_ctrl_oe),
    .ior_n(isa_if.ior_n), .iow_n(isa_if.iow_n), .memr_n(isa_if.memr_n),
    .memw_n(isa_if.memw_n), .sbhe_n(isa_if.sbhe_n), .nic_reset_n(isa_if.nic_reset_n),
    .intrq(isa_if.intrq));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one processor access; lat counts cycles from take to answer
  task automatic do_req(input logic [31:0] a, input logic w, input logic b,
                        input logic [15:0] d, output logic [15:0] q, output int lat);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    i_req_valid = 1'b1;
    i_req_addr = a;
    i_req_write = w;
    i_req_byte = b;
    i_req_wdata = d;
    @(negedge i_sys_clk);
    i_req_valid = 1'b0;
    lat = 1;
    while (o_rsp_valid !== 1'b1 && lat < 100) begin
      @(negedge i_sys_clk);
      lat++;
    end
    q = o_rsp_rdata;
  endtask

  // valid held across both bytes so no same-step toggle
  task automatic rx_pair(input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    while (o_rx_ready !== 1'b1 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    i_rx_valid = 1'b1;
    i_rx_byte = a;
    @(negedge i_sys_clk);
    while (o_rx_ready !== 1'b1 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    i_rx_byte = b;
    @(negedge i_sys_clk);
    i_rx_valid = 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_banks;
    logic [15:0] q;
    int lat;
    logic [3:0] f;
    i_bank_wait = 16'h0153;
    do_req(32'h0000_0000, 1'b0, 1'b0, 16'h0, q, lat);
    chk("unmapped latency", 16'h1, 16'(lat));
    chk("unmapped data", 16'h0, q);
    for (int n = 0; n < 4; n++) begin
      if (n != 2) begin
        f = i_bank_wait[4*n +: 4];
        do_req(32'h6000_0000 + n * 32'h0200_0000, 1'b0, 1'b0, 16'h0, q, lat);
        chk("bank latency", 16'(f) + 16'h2, 16'(lat));
        chk("bank data", 16'h0, q);
      end
    end
    do_req(32'h6400_0000, 1'b0, 1'b0, 16'h0, q, lat);
    chk("bank two floor latency", 16'h9, 16'(lat));
    chk("bank two off-device data", 16'h0, q);
  endtask

  task automatic t_nic_waits;
    logic [15:0] q;
    int lat;
    i_bank_wait = 16'h0000;
    do_req(32'h6480_0302, 1'b0, 1'b0, 16'h0, q, lat);
    chk("default wait latency", 16'ha, 16'(lat));
    i_bank_wait = 16'h0900;
    do_req(32'h6480_0302, 1'b0, 1'b0, 16'h0, q, lat);
    chk("long wait latency", 16'hb, 16'(lat));
    i_bank_wait = 16'h0000;
  endtask

  task automatic t_mode16;
    logic [15:0] q;
    int lat;
    chk("bus16 after reset", 16'h0, 16'(o_bus16));
    do_req(32'h6480_0300, 1'b0, 1'b1, 16'h0, q, lat);
    do_req(32'h6480_0301, 1'b0, 1'b1, 16'h0, q, lat);
    do_req(32'h6480_0300, 1'b0, 1'b1, 16'h0, q, lat);
    chk("bus16 after dummy reads", 16'h1, 16'(o_bus16));
  endtask

  task automatic t_rx;
    logic [15:0] q;
    int lat;
    rx_pair(8'h01, 8'h02);
    repeat (3) @(negedge i_sys_clk);
    chk("irq on word", 16'h1, 16'(o_ext_irq));
    do_req(32'h6480_0302, 1'b0, 1'b0, 16'h0, q, lat);
    chk("status with word", 16'h0003, q);
    do_req(32'h6480_0300, 1'b0, 1'b0, 16'h0, q, lat);
    chk("first rx word", 16'h0201, q);
    repeat (3) @(negedge i_sys_clk);
    chk("irq after read", 16'h0, 16'(o_ext_irq));
    rx_pair(8'h03, 8'h04);
    do_req(32'h6480_0300, 1'b0, 1'b0, 16'h0, q, lat);
    chk("second rx word", 16'h0403, q);
  endtask

  task automatic t_mem;
    logic [15:0] q;
    int lat;
    do_req(32'h6480_0304, 1'b1, 1'b0, MEM_BASE_SETTING, q, lat);
    do_req(32'h6480_1000, 1'b1, 1'b0, 16'hbeef, q, lat);
    do_req(32'h6480_1002, 1'b1, 1'b0, 16'h1234, q, lat);
    do_req(32'h6480_1000, 1'b0, 1'b0, 16'h0, q, lat);
    chk("memory word low", 16'hbeef, q);
    do_req(32'h6480_1002, 1'b0, 1'b0, 16'h0, q, lat);
    chk("memory word next", 16'h1234, q);
  endtask

  task automatic t_nic_reset;
    i_nic_reset = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk("bus16 in nic reset", 16'h0, 16'(o_bus16));
    i_nic_reset = 1'b0;
    repeat (2) @(negedge i_sys_clk);
  endtask

  // ****************************************
  // timeout and main sequence
  // ****************************************
  // ceiling well above the few hundred cycles the run needs
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    @(negedge i_sys_clk);
    t_banks();
    t_nic_waits();
    t_mode16();
    t_rx();
    t_mem();
    t_nic_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
